// ### hw/compressor_two_consts.svh
// Functional notes
// R1: Effects status word bits 15:4 are read-only path enable flags, 1 means enabled.
// R2: Flags 11:8 equalisers 4..1, 7:6 compressor two R/L, 5:4 one R/L, 3:0 filters.
// R3: Attack rate bits 31:28, 181 us doubling to 185.6 ms; 0 and 12-15 reserved; reset 4.
// R4: Decay rate bits 27:24, 1.45 ms doubling to 2.97 s; 12-15 reserved; reset 9.
// R5: Floor gain bits 20:18, 0/-12/-18/-24/-36 dB; others reserved; reset 100.
// R6: Ceiling gain bits 17:16, 12/18/24/36 dB; reset 11.
// R7: RMS detect threshold bits 15:11, -30 dB down in 1.5 dB steps.
// R8: Crest threshold bits 10:9, 12/18/24/30 dB, used in peak mode only.
// R9: Detect mode bit 7, 0 peak, 1 RMS; resets to 0.
// R10: Enables: gate 8, detect 6, knee two 5, quick release 4, clip guard 3.
// R11: Compressor path enable refused when clock too slow; running paths stay untouched.
// R12: Reserved rate or gain codes are ignored; previous valid setting is kept.
`ifndef COMPRESSOR_TWO_CONSTS_SVH
`define COMPRESSOR_TWO_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_EFFECTS_ENABLE_STATUS      16'ha804
`define ADDR_PATH_REQUEST   16'ha808
`define ADDR_IRQ_STATUS     16'ha810
`define ADDR_IRQ_MASK       16'ha814
`define ADDR_COMP2_CTRL_B   16'hab18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FX_FLAGS_LSB        4
`define FX_FLAGS_MSB        15
`define NUM_PATHS           12
`define COMP2_RIGHT_BIT     7
`define COMP2_LEFT_BIT      6
`define COMP_FIRST_BIT      4
`define COMP_LAST_BIT       7
`define ATK_MSB             31
`define ATK_LSB             28
`define DCY_MSB             27
`define DCY_LSB             24
`define MINGAIN_MSB         20
`define MINGAIN_LSB         18
`define MAXGAIN_MSB         17
`define MAXGAIN_LSB         16
`define RMS_MSB             15
`define RMS_LSB             11
`define PK_MSB              10
`define PK_LSB              9
`define NG_BIT              8
`define MODE_BIT            7
`define DET_BIT             6
`define KNEE2_BIT           5
`define QR_BIT              4
`define ANTICLIP_BIT        3
`define CTRL_WRITE_MASK     32'hff1f_fff8
`define IRQ_REFUSED_BIT     0
`define IRQ_DETECT_BIT      1
`define IRQ_WIDTH           2

// ----------------------------------------------------------------
// Reset values and code limits
// ----------------------------------------------------------------
`define CTRL_RESET          32'h4913_0018
`define ATK_RESERVED_LOW    4'h0
`define RATE_LAST_VALID     4'hb
`define MINGAIN_LAST_VALID  3'h4

// ----------------------------------------------------------------
// Detector scaling, all levels in 1.5 dB steps; RMS counted down from full scale, crest counted upward
// ----------------------------------------------------------------
`define RMS_BASE_STEPS      7'h14
`define CREST_BASE_STEPS    6'h08
`define CREST_STEP_STEPS    6'h04

`endif

// ### hw/compressor_two_pkg.sv
package compressor_two_pkg;

	typedef enum logic {
		DETECT_PEAK = 1'b0,
		DETECT_RMS  = 1'b1
	} detect_mode_t;

	typedef logic [3:0]  rate_code_t;
	typedef logic [2:0]  floor_code_t;
	typedef logic [1:0]  ceiling_code_t;
	typedef logic [31:0] word_t;

endpackage

// ### hw/path_enable_gate.sv
`timescale 1ns/100ps
module path_enable_gate #(
	parameter bit CLOCK_CHECKED = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Request and clock adequacy
	input  wire logic request,
	input  wire logic clock_ok,
	// Path state
	output logic      active,
	output logic      refused
);

	logic request_q;
	logic request_d;
	logic active_q;
	logic active_d;
	logic refused_q;
	logic refused_d;

	always_comb begin
		request_d = request;
		active_d  = active_q;
		refused_d = 1'b0;
		if (!request) begin
			active_d = 1'b0;
		end else if (!request_q && !active_q) begin
			// Only the attempt itself is checked; a running path is never dropped
			if (CLOCK_CHECKED && !clock_ok) begin
				refused_d = 1'b1; // R11
			end else begin
				active_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			request_q <= 1'b0;
			active_q  <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			request_q <= request_d;
			active_q  <= active_d;
			refused_q <= refused_d;
		end
	end

	assign active  = active_q;
	assign refused = refused_q;

endmodule

// ### hw/compressor_two_control.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "compressor_two_consts.svh"
module compressor_two_control (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Avalon-MM slave
	input  wire logic [15:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Clock adequacy pin, asynchronous
	input  wire logic        clock_ok_pin,
	// Level detector feed
	input  wire logic        level_valid,
	input  wire logic [6:0]  rms_level_down,
	input  wire logic [5:0]  crest_level,
	// Path state
	output logic      [11:0] path_active,
	// Compressor two settings
	output logic      [3:0]  gain_attack_rate,
	output logic      [3:0]  gain_decay_rate,
	output logic      [2:0]  floor_gain_limit,
	output logic      [1:0]  ceiling_gain_limit,
	output logic      [4:0]  rms_detect_threshold,
	output logic      [1:0]  crest_detect_threshold,
	output logic             noise_gate_on,
	output logic             detect_threshold_select,
	output logic             signal_detect_on,
	output logic             second_knee_output_on,
	output logic             quick_release_on,
	output logic             clip_guard_on,
	// Detection and interrupt
	output logic             signal_detected,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Clock adequacy synchroniser
	// ----------------------------------------------------------------
	logic clk_ok_meta_q;
	logic clk_ok_meta_d;
	logic clk_ok_sync_q;
	logic clk_ok_sync_d;

	// The pin may move at any instant, so logic reads only the second stage
	always_comb begin
		clk_ok_meta_d = clock_ok_pin;
		clk_ok_sync_d = clk_ok_meta_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_ok_meta_q <= 1'b0;
			clk_ok_sync_q <= 1'b0;
		end else begin
			clk_ok_meta_q <= clk_ok_meta_d;
			clk_ok_sync_q <= clk_ok_sync_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus handshake: one wait cycle, answer on the second
	// ----------------------------------------------------------------
	logic ack_q;
	logic ack_d;
	logic take;
	logic wr_take;
	logic rd_take;

	// A fixed single wait state lets read data come straight from a flip-flop
	always_comb begin
		ack_d = (read || write) && !ack_q;
	end

	assign waitrequest = (read || write) && !ack_q;
	assign take        = ack_q && (read || write);
	assign wr_take     = take && write;
	assign rd_take     = take && read;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic hit_request;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_ctrl;

	always_comb begin
		hit_request    = address == `ADDR_PATH_REQUEST;
		hit_irq_status = address == `ADDR_IRQ_STATUS;
		hit_irq_mask   = address == `ADDR_IRQ_MASK;
		hit_ctrl       = address == `ADDR_COMP2_CTRL_B;
	end

	// ----------------------------------------------------------------
	// Path enable requests and gating
	// ----------------------------------------------------------------
	logic [11:0] request_q;
	logic [11:0] request_d;
	logic [11:0] active_w;
	logic [11:0] refused_w;

	always_comb begin
		request_d = request_q;
		if (wr_take && hit_request) begin
			if (byteenable[0]) begin
				request_d[7:0] = writedata[7:0];
			end
			// Upper lane holds only the four equaliser requests
			if (byteenable[1]) begin
				request_d[11:8] = writedata[11:8];
			end
		end
	end

	// Only compressor paths are held back by a slow clock
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_PATHS; gi++) begin : g_path
			path_enable_gate #(
				.CLOCK_CHECKED(gi >= `COMP_FIRST_BIT && gi <= `COMP_LAST_BIT)
			) u_gate (
				.clk     (clk),
				.rst_b   (rst_b),
				.request (request_q[gi]),
				.clock_ok(clk_ok_sync_q),
				.active  (active_w[gi]), // R2
				.refused (refused_w[gi])
			);
		end
	endgenerate

	assign path_active = active_w;

	// ----------------------------------------------------------------
	// Control word with reserved-code filtering
	// ----------------------------------------------------------------
	compressor_two_pkg::word_t ctrl_q;
	compressor_two_pkg::word_t ctrl_d;
	compressor_two_pkg::word_t merged;

	always_comb begin
		merged = ctrl_q;
		for (int b = 0; b < 4; b++) begin
			if (byteenable[b]) begin
				merged[8*b +: 8] = writedata[8*b +: 8];
			end
		end
		// Reserved bits never store, so they always read back as zero
		merged = merged & `CTRL_WRITE_MASK;
		ctrl_d = ctrl_q;
		if (wr_take && hit_ctrl) begin
			ctrl_d = merged;
			// A reserved code leaves only its own field as it was
			if (merged[`ATK_MSB:`ATK_LSB] == `ATK_RESERVED_LOW
				|| merged[`ATK_MSB:`ATK_LSB] > `RATE_LAST_VALID) begin
				ctrl_d[`ATK_MSB:`ATK_LSB] = ctrl_q[`ATK_MSB:`ATK_LSB]; // R3 R12
			end
			if (merged[`DCY_MSB:`DCY_LSB] > `RATE_LAST_VALID) begin
				ctrl_d[`DCY_MSB:`DCY_LSB] = ctrl_q[`DCY_MSB:`DCY_LSB]; // R4 R12
			end
			if (merged[`MINGAIN_MSB:`MINGAIN_LSB] > `MINGAIN_LAST_VALID) begin
				ctrl_d[`MINGAIN_MSB:`MINGAIN_LSB] =
					ctrl_q[`MINGAIN_MSB:`MINGAIN_LSB]; // R5 R12
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q    <= `CTRL_RESET; // R3 R4 R5 R6 R9 R10
			request_q <= 12'h000;
			ack_q     <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			request_q <= request_d;
			ack_q     <= ack_d;
		end
	end

	assign gain_attack_rate        = ctrl_q[`ATK_MSB:`ATK_LSB]; // R3
	assign gain_decay_rate         = ctrl_q[`DCY_MSB:`DCY_LSB]; // R4
	assign floor_gain_limit        = ctrl_q[`MINGAIN_MSB:`MINGAIN_LSB]; // R5
	assign ceiling_gain_limit      = ctrl_q[`MAXGAIN_MSB:`MAXGAIN_LSB]; // R6
	assign rms_detect_threshold    = ctrl_q[`RMS_MSB:`RMS_LSB]; // R7
	assign crest_detect_threshold  = ctrl_q[`PK_MSB:`PK_LSB]; // R8
	assign noise_gate_on           = ctrl_q[`NG_BIT]; // R10
	assign detect_threshold_select = ctrl_q[`MODE_BIT]; // R9
	assign signal_detect_on        = ctrl_q[`DET_BIT]; // R10
	assign second_knee_output_on   = ctrl_q[`KNEE2_BIT]; // R10
	assign quick_release_on        = ctrl_q[`QR_BIT]; // R10
	assign clip_guard_on           = ctrl_q[`ANTICLIP_BIT]; // R10

	// ----------------------------------------------------------------
	// Signal detector
	// ----------------------------------------------------------------
	// Levels arrive as 1.5 dB steps so every threshold is a plain compare
	logic       detect_q;
	logic       detect_d;
	logic [6:0] rms_limit;
	logic [5:0] crest_limit;
	logic       over_threshold;
	logic       comp2_running;

	always_comb begin
		rms_limit   = `RMS_BASE_STEPS + {2'b00, ctrl_q[`RMS_MSB:`RMS_LSB]}; // R7
		crest_limit = `CREST_BASE_STEPS
			+ 6'(`CREST_STEP_STEPS * {4'h0, ctrl_q[`PK_MSB:`PK_LSB]}); // R8
		// Detection only means something while a compressor two path runs
		comp2_running = active_w[`COMP2_RIGHT_BIT] || active_w[`COMP2_LEFT_BIT];
		if (compressor_two_pkg::detect_mode_t'(ctrl_q[`MODE_BIT])
			== compressor_two_pkg::DETECT_RMS) begin
			over_threshold = rms_level_down <= rms_limit; // R9
		end else begin
			over_threshold = crest_level >= crest_limit; // R8 R9
		end
		detect_d = detect_q;
		if (!ctrl_q[`DET_BIT] || !comp2_running) begin
			detect_d = 1'b0; // R10
		end else if (level_valid) begin
			detect_d = over_threshold;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, mask and read data
	// ----------------------------------------------------------------
	logic [1:0]  irq_status_q;
	logic [1:0]  irq_status_d;
	logic [1:0]  irq_mask_q;
	logic [1:0]  irq_mask_d;
	logic [1:0]  events;
	logic [31:0] readdata_q;
	logic [31:0] readdata_d;

	always_comb begin
		events = 2'b00;
		events[`IRQ_REFUSED_BIT] = |refused_w; // R11
		events[`IRQ_DETECT_BIT]  = detect_d && !detect_q;
		irq_status_d = irq_status_q;
		// Clearing read and a new event in the same cycle keep the event
		if (rd_take && hit_irq_status) begin
			// Only bits already returned are cleared; an event during the read survives
			irq_status_d = irq_status_q & ~readdata_q[`IRQ_WIDTH-1:0];
		end
		irq_status_d = irq_status_d | events;
		irq_mask_d = irq_mask_q;
		// Mask bits sit in the lowest byte lane
		if (wr_take && hit_irq_mask && byteenable[0]) begin
			irq_mask_d = writedata[`IRQ_WIDTH-1:0];
		end
		// Captured in the wait cycle so the answer stands in a register
		readdata_d = readdata_q;
		if ((read || write) && !ack_q) begin
			readdata_d = 32'h0000_0000;
			if (read) begin
				case (address)
					`ADDR_EFFECTS_ENABLE_STATUS: begin
						readdata_d[`FX_FLAGS_MSB:`FX_FLAGS_LSB] = active_w; // R1 R11
					end
					`ADDR_PATH_REQUEST: begin
						readdata_d[11:0] = request_q;
					end
					`ADDR_IRQ_STATUS: begin
						readdata_d[`IRQ_WIDTH-1:0] = irq_status_q;
					end
					`ADDR_IRQ_MASK: begin
						readdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
					end
					`ADDR_COMP2_CTRL_B: begin
						readdata_d = ctrl_q;
					end
					default: begin
						readdata_d = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			detect_q     <= 1'b0;
			irq_status_q <= 2'b00;
			irq_mask_q   <= 2'b00;
			readdata_q   <= 32'h0000_0000;
		end else begin
			detect_q     <= detect_d;
			irq_status_q <= irq_status_d;
			irq_mask_q   <= irq_mask_d;
			readdata_q   <= readdata_d;
		end
	end

	assign signal_detected = detect_q;
	assign irq             = |(irq_status_q & irq_mask_q);
	assign readdata        = readdata_q;

endmodule

// ### tb/compressor_two_control_chk.sv
`timescale 1ns/100ps
module compressor_two_control_chk (
	// Bus
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [15:0] address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Paths and settings
	input wire logic        clock_ok_pin,
	input wire logic [11:0] path_active,
	input wire logic [3:0]  gain_attack_rate,
	input wire logic [3:0]  gain_decay_rate,
	input wire logic [2:0]  floor_gain_limit,
	input wire logic [1:0]  ceiling_gain_limit,
	input wire logic [4:0]  rms_detect_threshold,
	input wire logic [1:0]  crest_detect_threshold,
	input wire logic        noise_gate_on,
	input wire logic        detect_threshold_select,
	input wire logic        signal_detect_on,
	input wire logic        second_knee_output_on,
	input wire logic        quick_release_on,
	input wire logic        clip_guard_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// --------
	// Completed accesses
	// --------
	sequence s_done;
		(read || write) && !waitrequest;
	endsequence
	sequence s_ctrl_wr;
		s_done ##0 write && address == 16'hab18;
	endsequence

	a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer after one wait");
	a_status_read: assert property (s_done ##0 read && address == 16'ha804 &&
		$stable(path_active) |-> readdata == {16'h0000, path_active, 4'h0})
		else $error("status word mismatch");
	a_attack_write: assert property (s_ctrl_wr ##0 byteenable[3] &&
		writedata[31:28] != 4'h0 && writedata[31:28] <= 4'hb
		|=> {gain_attack_rate, 28'h0} == ($past(writedata) & 32'hf000_0000))
		else $error("attack write lost");
	a_decay_write: assert property (s_ctrl_wr ##0 byteenable[3] &&
		writedata[27:24] <= 4'hb
		|=> {gain_decay_rate, 24'h0} == ($past(writedata) & 32'h0f00_0000))
		else $error("decay write lost");
	a_code_range: assert property (gain_attack_rate != 4'h0 &&
		gain_attack_rate <= 4'hb && gain_decay_rate <= 4'hb && floor_gain_limit <= 3'h4)
		else $error("reserved code applied");
	a_floor_hold: assert property (s_ctrl_wr ##0 byteenable[2] &&
		writedata[20:18] > 3'h4 |=> $stable(floor_gain_limit))
		else $error("reserved floor taken");
	a_ceiling_write: assert property (s_ctrl_wr ##0 byteenable[2]
		|=> {14'h0, ceiling_gain_limit, 16'h0} == ($past(writedata) & 32'h0003_0000))
		else $error("ceiling write lost");
	a_detect_write: assert property (s_ctrl_wr ##0 byteenable[1] |=>
		{16'h0, rms_detect_threshold, crest_detect_threshold, noise_gate_on, 8'h0}
		== ($past(writedata) & 32'h0000_ff00))
		else $error("detect fields lost");
	a_low_lane: assert property (s_ctrl_wr ##0 byteenable[0] |=>
		{24'h0, detect_threshold_select, signal_detect_on, second_knee_output_on,
		quick_release_on, clip_guard_on, 3'h0} == ($past(writedata) & 32'h0000_00f8))
		else $error("enable bits lost");
	a_slow_refuse: assert property ((!clock_ok_pin)[*5] ##0 path_active[7:4] == 4'h0
		|=> path_active[7:4] == 4'h0)
		else $error("path enabled on slow clock");
endmodule

bind compressor_two_control compressor_two_control_chk chk (.*);

// ### tb/tb_compressor_two_control.sv
`timescale 1ns/100ps
module tb_compressor_two_control;
	logic        clk, rst_b, read, write, waitrequest, clock_ok_pin, level_valid;
	logic [15:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable, gain_attack_rate, gain_decay_rate;
	logic [6:0]  rms_level_down;
	logic [5:0]  crest_level;
	logic [11:0] path_active;
	logic [2:0]  floor_gain_limit;
	logic [1:0]  ceiling_gain_limit, crest_detect_threshold;
	logic [4:0]  rms_detect_threshold;
	logic        noise_gate_on, detect_threshold_select, signal_detect_on;
	logic        second_knee_output_on, quick_release_on, clip_guard_on;
	logic        signal_detected, irq;
	int          failures, n_compared;

	compressor_two_control uut (.*);

	// --------
	// Shared tasks
	// --------
	task automatic end_sim;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Waits on waitrequest with a bound so a stuck slave ends the run
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= w;
		read <= !w;
		// Sampled at the edge itself, before that edge's updates land
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			failures++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		chk(q, e);
	endtask

	// --------
	// Scenarios
	// --------
	task automatic t_fields;
		rd(16'hab18, 32'h4913_0018);
		rd(16'ha804, 32'h0000_0000);
		wr(16'hab18, 32'hb000_ffe0);
		rd(16'hab18, 32'hb000_ffe0);
		wr(16'hab18, 32'h0cd7_001f);
		rd(16'hab18, 32'hb003_0018);
		bus(1'b1, 16'hab18, 32'hffff_ffff, 4'h5);
		rd(16'hab18, 32'hb003_00f8);
		wr(16'ha804, 32'hffff_ffff);
		rd(16'ha804, 32'h0000_0000);
		rd(16'ha900, 32'h0000_0000);
	endtask

	task automatic t_paths;
		for (int i = 0; i < 12; i++) begin
			wr(16'ha808, 32'h0000_0001 << i);
			repeat (3) @(negedge clk);
			chk(path_active, 12'h001 << i);
		end
		rd(16'ha804, 32'h0000_8000);
	endtask

	task automatic t_refuse;
		wr(16'ha814, 32'h0000_0003);
		clock_ok_pin <= 1'b0;
		repeat (4) @(posedge clk);
		wr(16'ha808, 32'h0000_01f0);
		repeat (3) @(negedge clk);
		chk(path_active, 12'h100);
		chk(irq, 1'b1);
		rd(16'ha810, 32'h0000_0001);
		@(negedge clk);
		chk(irq, 1'b0);
		@(posedge clk);
		clock_ok_pin <= 1'b1;
		repeat (4) @(posedge clk);
		wr(16'ha808, 32'h0000_0100);
		wr(16'ha808, 32'h0000_01f0);
		@(posedge clk);
		clock_ok_pin <= 1'b0;
		repeat (6) @(negedge clk);
		chk(path_active, 12'h1f0);
	endtask

	task automatic det(input logic [31:0] c, input logic [6:0] r, input logic [5:0] k,
		input logic e);
		wr(16'hab18, c);
		@(posedge clk);
		level_valid <= 1'b1;
		rms_level_down <= r;
		crest_level <= k;
		@(posedge clk);
		level_valid <= 1'b0;
		@(negedge clk);
		chk(signal_detected, e);
	endtask

	// Boundary levels, each with the other mode's level on the opposite side of its threshold
	task automatic t_detect;
		det(32'h4900_00c0, 7'h14, 6'h00, 1'b1);
		det(32'h4900_00c0, 7'h15, 6'h3f, 1'b0);
		det(32'h4900_0640, 7'h7f, 6'h14, 1'b1);
		det(32'h4900_0640, 7'h00, 6'h13, 1'b0);
		chk(irq, 1'b1);
		rd(16'ha810, 32'h0000_0002);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 16'h0000;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
		clock_ok_pin = 1'b1;
		level_valid = 1'b0;
		rms_level_down = 7'h00;
		crest_level = 6'h00;
		failures = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_fields();
		t_paths();
		t_refuse();
		t_detect();
		end_sim();
	end
endmodule
